//--- rtl/vcb_pkg.sv
// Package for the video capture buffer handshake block.
// Assumes a 32-bit classic Wishbone register bus on a single core clock.
package vcb_pkg;
    // Register byte offsets
    localparam logic [3:0] CTRL_OFFS = 4'h0;
    localparam logic [3:0] MISC_OFFS = 4'h4;
    localparam logic [3:0] IRQ_MASK_OFFS = 4'h8;
    localparam logic [3:0] IRQ_STAT_OFFS = 4'hc;
    // Capture port control fields
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_B1_BIT = 1;
    localparam int CTRL_B2_BIT = 2;
    localparam int CTRL_COND_BIT = 8;
    localparam int CTRL_DBL_BIT = 9;
    localparam int CTRL_ILACE_BIT = 10;
    // Misc control field
    localparam int MISC_AUTO_BIT = 24;
    // Reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] MISC_RST = 32'h0000_0000;
    localparam logic [2:0] IRQ_RST = 3'h0;
    // Interrupt status bits
    localparam int IRQ_FRAME_BIT = 0;
    localparam int IRQ_B1_DONE_BIT = 1;
    localparam int IRQ_B2_DONE_BIT = 2;
    // Capture state machine
    typedef enum logic [1:0] {
        VCB_IDLE,
        VCB_WAIT,
        VCB_CAPT
    } vcb_state_t;
endpackage

//--- rtl/vcb_regs.sv
// Small register store for the capture block's software-owned words.
// Assumes one write port driven by the bus slave in the same clock domain.
`timescale 1ns/1ns
module vcb_regs #(
    parameter int WIDTH = 32
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Write port
    input wire logic we_i,
    input wire logic [WIDTH-1:0] wdata_i,
    input wire logic [WIDTH/8-1:0] sel_i,
    input wire logic [WIDTH-1:0] rst_val_i,
    // Stored word
    output logic [WIDTH-1:0] q_o
);
    // Byte lanes written independently, one register each
    genvar g;
    generate
        for (g = 0; g < WIDTH / 8; g++)
        begin : g_lane
            logic [7:0] lane_q;

            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    lane_q <= rst_val_i[g*8 +: 8];
                else if (we_i && sel_i[g])
                    lane_q <= wdata_i[g*8 +: 8];
            end

            assign q_o[g*8 +: 8] = lane_q;
        end
    endgenerate
endmodule

//--- rtl/vcb_top.sv
// Capture buffer handshake: mode select, buffer flags, overlay pointer.
// Assumes frame start/end pulses from capture datapath on clk_i and a
// blit engine that sets buffer flags through its own set strobes.
//
// Local design decisions: the register offsets and the Wishbone register port.
`timescale 1ns/1ns
// Operation
// - Buffer-one flag at bit 1, buffer-two flag at bit 2.
// - Bit 8 one selects conditional capture, zero continuous.
// - Single continuous: every frame to buffer one, flags ignored.
// - Single conditional: wait flag one, capture, clear flag, wait again.
// - Double continuous: alternate buffers each frame, flags ignored.
// - Double conditional: capture into buffer with flag one, then clear it.
// - Double conditional: keep capturing while any flag one, else monitor.
// - Misc bit 24 one: auto display capture on overlay window one.
// - Auto display, double mode: overlay shows buffer not being written.
// - Bit 9 one selects double buffering, zero single.
// - Bit 10 selects interlaced when bit 9 is one; buffers combine, one line offset.
module vcb_top
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // Capture datapath
    input wire logic frame_start_i,
    input wire logic frame_end_i,
    output logic capture_go_o,
    output logic capture_buf_o,
    output logic interlaced_o,
    // Blit engine flag sets
    input wire logic blit_set_b1_i,
    input wire logic blit_set_b2_i,
    // Overlay window one
    output logic overlay_auto_o,
    output logic overlay_buf_o,
    // Interrupt
    output logic irq_o
);
    logic [31:0] ctrl_q;
    logic [31:0] misc_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic ack_q;
    logic [31:0] rdata_q;
    logic wr_stb;
    logic rd_stb;
    logic cap_en;
    logic cond_mode;
    logic dbl_mode;
    logic auto_disp;
    logic b1_flag;
    logic b2_flag;
    logic wbuf_q;
    logic capturing_q;
    logic frame_done;
    logic clr_b1;
    logic clr_b2;
    vcb_pkg::vcb_state_t state_q;

    // One wait state; writes land on the edge where the master sees ack
    assign wr_stb = cyc_i && stb_i && we_i && ack_q;
    assign rd_stb = cyc_i && stb_i && !we_i && !ack_q;
    assign ack_o = ack_q;
    assign dat_o = rdata_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_q <= 1'b0;
        else
            ack_q <= cyc_i && stb_i && !ack_q;
    end

    // Misc control word lives in the byte-lane store
    vcb_regs #(
        .WIDTH(32)
    ) u_misc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(wr_stb && adr_i == vcb_pkg::MISC_OFFS),
        .wdata_i(dat_i),
        .sel_i(sel_i),
        .rst_val_i(vcb_pkg::MISC_RST),
        .q_o(misc_q)
    );

    assign cap_en = ctrl_q[vcb_pkg::CTRL_EN_BIT];
    assign cond_mode = ctrl_q[vcb_pkg::CTRL_COND_BIT];
    assign dbl_mode = ctrl_q[vcb_pkg::CTRL_DBL_BIT];
    assign auto_disp = misc_q[vcb_pkg::MISC_AUTO_BIT];
    assign b1_flag = ctrl_q[vcb_pkg::CTRL_B1_BIT];
    assign b2_flag = ctrl_q[vcb_pkg::CTRL_B2_BIT];
    assign frame_done = capturing_q && frame_end_i;
    // Hardware clears only the buffer it just filled, in conditional mode
    assign clr_b1 = frame_done && cond_mode && !wbuf_q;
    assign clr_b2 = frame_done && cond_mode && wbuf_q && dbl_mode;

    // Control word: software writes, hardware clears flags, blit sets win
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ctrl_q <= vcb_pkg::CTRL_RST;
        else
        begin
            if (wr_stb && adr_i == vcb_pkg::CTRL_OFFS)
            begin
                if (sel_i[0])
                    ctrl_q[7:0] <= dat_i[7:0];
                if (sel_i[1])
                    ctrl_q[15:8] <= dat_i[15:8];
                if (sel_i[2])
                    ctrl_q[23:16] <= dat_i[23:16];
                if (sel_i[3])
                    ctrl_q[31:24] <= dat_i[31:24];
            end
            // Clear loses to a set arriving in the same cycle
            if (clr_b1)
                ctrl_q[vcb_pkg::CTRL_B1_BIT] <= 1'b0;
            if (clr_b2)
                ctrl_q[vcb_pkg::CTRL_B2_BIT] <= 1'b0;
            if (blit_set_b1_i)
                ctrl_q[vcb_pkg::CTRL_B1_BIT] <= 1'b1;
            if (blit_set_b2_i)
                ctrl_q[vcb_pkg::CTRL_B2_BIT] <= 1'b1;
        end
    end

    // Capture sequencer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= vcb_pkg::VCB_IDLE;
            capturing_q <= 1'b0;
            wbuf_q <= 1'b0;
        end
        else if (!cap_en)
        begin
            state_q <= vcb_pkg::VCB_IDLE;
            capturing_q <= 1'b0;
        end
        else
        begin
            case (state_q)
                vcb_pkg::VCB_IDLE:
                begin
                    state_q <= vcb_pkg::VCB_WAIT;
                end
                vcb_pkg::VCB_WAIT:
                begin
                    if (frame_start_i)
                    begin
                        if (!cond_mode)
                        begin
                            // Flags ignored in continuous capture
                            capturing_q <= 1'b1;
                            state_q <= vcb_pkg::VCB_CAPT;
                            if (!dbl_mode)
                                wbuf_q <= 1'b0;
                        end
                        else if (b1_flag)
                        begin
                            capturing_q <= 1'b1;
                            wbuf_q <= 1'b0;
                            state_q <= vcb_pkg::VCB_CAPT;
                        end
                        else if (dbl_mode && b2_flag)
                        begin
                            capturing_q <= 1'b1;
                            wbuf_q <= 1'b1;
                            state_q <= vcb_pkg::VCB_CAPT;
                        end
                    end
                end
                vcb_pkg::VCB_CAPT:
                begin
                    if (frame_end_i)
                    begin
                        capturing_q <= 1'b0;
                        // Back to monitoring; next frame rechecks flags
                        state_q <= vcb_pkg::VCB_WAIT;
                        if (dbl_mode && !cond_mode)
                            wbuf_q <= !wbuf_q;
                    end
                end
                default:
                begin
                    state_q <= vcb_pkg::VCB_IDLE;
                    capturing_q <= 1'b0;
                end
            endcase
        end
    end

    assign capture_go_o = capturing_q;
    assign capture_buf_o = wbuf_q;
    // Interlaced pairs both buffers as one, offset by a line
    assign interlaced_o = ctrl_q[vcb_pkg::CTRL_ILACE_BIT] && dbl_mode;
    assign overlay_auto_o = auto_disp;
    // Show the buffer not being written; single mode only has buffer one
    assign overlay_buf_o = auto_disp && dbl_mode && !wbuf_q;

    // Interrupt status: frame done, buffer one flag cleared, buffer two flag cleared
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_stat_q <= vcb_pkg::IRQ_RST;
            irq_mask_q <= vcb_pkg::IRQ_RST;
        end
        else
        begin
            if (wr_stb && adr_i == vcb_pkg::IRQ_MASK_OFFS && sel_i[0])
                irq_mask_q <= dat_i[2:0];
            // Set wins over write-one-to-clear
            irq_stat_q <= (irq_stat_q
                & ~((wr_stb && adr_i == vcb_pkg::IRQ_STAT_OFFS && sel_i[0]) ? dat_i[2:0] : 3'h0))
                | {clr_b2, clr_b1, frame_done};
        end
    end

    assign irq_o = |(irq_stat_q & irq_mask_q);

    // Read data registered; unmapped offsets read zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            rdata_q <= 32'h0000_0000;
        else if (rd_stb)
        begin
            case (adr_i)
                vcb_pkg::CTRL_OFFS: rdata_q <= ctrl_q;
                vcb_pkg::MISC_OFFS: rdata_q <= misc_q;
                vcb_pkg::IRQ_MASK_OFFS: rdata_q <= {29'h0, irq_mask_q};
                vcb_pkg::IRQ_STAT_OFFS: rdata_q <= {29'h0, irq_stat_q};
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // Assertions
    sequence s_frame_cond_b1;
        capturing_q && cond_mode && !wbuf_q && frame_end_i && !blit_set_b1_i;
    endsequence

    chk_cond_clear_b1: assert property (@(posedge clk_i) disable iff (rst_i)
        s_frame_cond_b1 |=> !b1_flag)
        else $error("buffer one flag not cleared after conditional frame");

    chk_dbl_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
        (cap_en && capturing_q && dbl_mode && !cond_mode && frame_end_i)
        |=> (wbuf_q != $past(wbuf_q)))
        else $error("double continuous did not switch buffer");

    chk_single_buf_one: assert property (@(posedge clk_i) disable iff (rst_i)
        (capturing_q && !dbl_mode) |-> !wbuf_q)
        else $error("single mode wrote buffer two");

    chk_cond_needs_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        ($rose(capturing_q) && cond_mode) |-> $past(b1_flag || b2_flag))
        else $error("conditional capture began with no flag set");

    chk_overlay_other: assert property (@(posedge clk_i) disable iff (rst_i)
        (auto_disp && dbl_mode) |-> (overlay_buf_o != wbuf_q))
        else $error("overlay shows buffer being written");

    chk_blit_set: assert property (@(posedge clk_i) disable iff (rst_i)
        blit_set_b2_i |=> b2_flag)
        else $error("blit set of buffer two flag lost");

    chk_reset_idle: assert property (@(posedge clk_i)
        rst_i |=> (!capturing_q && !wbuf_q && !b1_flag && !b2_flag))
        else $error("reset left capture state active");

    chk_auto_follow: assert property (@(posedge clk_i) disable iff (rst_i)
        overlay_auto_o == misc_q[vcb_pkg::MISC_AUTO_BIT])
        else $error("auto display does not follow control bit");

    chk_overlay_filled: assert property (@(posedge clk_i) disable iff (rst_i)
        (cap_en && auto_disp && dbl_mode && !cond_mode && frame_done)
        |=> (overlay_buf_o == $past(wbuf_q)))
        else $error("overlay does not show the buffer just filled");

    sequence s_frame_cond_b2;
        capturing_q && cond_mode && dbl_mode && wbuf_q && frame_end_i && !blit_set_b2_i;
    endsequence

    chk_cond_clear_b2: assert property (@(posedge clk_i) disable iff (rst_i)
        s_frame_cond_b2 |=> !b2_flag)
        else $error("buffer two flag not cleared after conditional frame");

    // Start of a conditional frame, split by the buffer it went to
    sequence s_cond_start_b1;
        $rose(capturing_q) && cond_mode && !wbuf_q;
    endsequence

    sequence s_cond_start_b2;
        $rose(capturing_q) && cond_mode && wbuf_q;
    endsequence

    chk_start_b1_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        s_cond_start_b1 |-> $past(b1_flag))
        else $error("buffer one capture began without its flag");

    // Buffer one is preferred when both flags are set
    chk_start_b2_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        s_cond_start_b2 |-> ($past(b2_flag) && !$past(b1_flag) && $past(dbl_mode)))
        else $error("buffer two capture began without its flag");

    chk_cont_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (cap_en && !cond_mode && state_q == vcb_pkg::VCB_WAIT && frame_start_i)
        |=> capturing_q)
        else $error("continuous capture missed a frame start");

    chk_cond_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        (cap_en && cond_mode && state_q == vcb_pkg::VCB_WAIT && frame_start_i
        && !b1_flag && !b2_flag) |=> !capturing_q)
        else $error("conditional capture began with both flags clear");

    // Continuous modes leave both flags to software and the blit engine
    chk_cont_keeps_flags: assert property (@(posedge clk_i) disable iff (rst_i)
        (frame_done && !cond_mode && !wr_stb && !blit_set_b1_i && !blit_set_b2_i)
        |=> (b1_flag == $past(b1_flag) && b2_flag == $past(b2_flag)))
        else $error("continuous frame changed a buffer flag");

    chk_single_keeps_b2: assert property (@(posedge clk_i) disable iff (rst_i)
        (frame_done && !dbl_mode && !wr_stb && !blit_set_b2_i)
        |=> (b2_flag == $past(b2_flag)))
        else $error("single buffer frame changed buffer two flag");

    chk_off_no_capture: assert property (@(posedge clk_i) disable iff (rst_i)
        !cap_en |=> !capturing_q)
        else $error("capture active while disabled");
endmodule

//--- verif/vcb_far_model.sv
// Far-side model: capture datapath frame pulses and blit engine flag sets.
// Assumes its tasks are called just after a rising clk_i edge.
`timescale 1ns/1ns
module vcb_far_model
(
    // Clock
    input wire logic clk_i,
    // Datapath and blit strobes
    output logic frame_start_o,
    output logic frame_end_o,
    output logic blit_set_b1_o,
    output logic blit_set_b2_o
);
    initial
    begin
        frame_start_o = 1'b0;
        frame_end_o = 1'b0;
        blit_set_b1_o = 1'b0;
        blit_set_b2_o = 1'b0;
    end
    task automatic start_frame();
        frame_start_o <= 1'b1;
        @(posedge clk_i);
        frame_start_o <= 1'b0;
    endtask
    task automatic end_frame();
        frame_end_o <= 1'b1;
        @(posedge clk_i);
        frame_end_o <= 1'b0;
    endtask
    // Flag raised only once a transfer is over, never mid-frame
    // Blit engine taken as set up for host reads with bus mastering on
    // Only used in conditional modes; continuous capture is for viewing
    task automatic blit_set(input logic [1:0] which);
        blit_set_b1_o <= which[0];
        blit_set_b2_o <= which[1];
        @(posedge clk_i);
        blit_set_b1_o <= 1'b0;
        blit_set_b2_o <= 1'b0;
    endtask
endmodule

//--- verif/tb_top.sv
// Testbench for the capture buffer handshake block.
// Assumes one 50 MHz clock and a classic Wishbone master in the bench.
`timescale 1ns/1ns
module tb_top;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, fs, fe, b1, b2;
    logic [3:0] adr_i;
    logic [31:0] dat_i, dat_o, q;
    logic go, bsel, ilace, oauto, obuf, irq;
    int failures = 0;
    int tests_run = 0;
    vcb_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .frame_start_i(fs), .frame_end_i(fe), .capture_go_o(go), .capture_buf_o(bsel),
        .interlaced_o(ilace), .blit_set_b1_i(b1), .blit_set_b2_i(b2),
        .overlay_auto_o(oauto), .overlay_buf_o(obuf), .irq_o(irq));
    vcb_far_model far (.clk_i(clk_i), .frame_start_o(fs), .frame_end_o(fe),
        .blit_set_b1_o(b1), .blit_set_b2_o(b2));
    initial
    begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task automatic give_verdict();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic check1(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask
    // Request held until ack is sampled, then one idle cycle
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        n = 0;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        if (ack_o !== 1'b1)
        begin
            failures++;
            $display("ERROR %0t bus timeout", $time);
            give_verdict();
        end
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // One frame; e_go says whether capture starts, e_buf and e_ovl the buffers
    task automatic frame(input logic e_go, input logic e_buf, input logic e_ovl);
        far.start_frame();
        repeat (2) @(posedge clk_i);
        check1(go, e_go);
        if (e_go)
        begin
            check1(bsel, e_buf);
            check1(obuf, e_ovl);
        end
        far.end_frame();
        @(posedge clk_i);
        check1(go, 1'b0);
    endtask
    initial
    begin
        rst_i = 1'b1;
        cyc_i = 1'b0;
        stb_i = 1'b0;
        we_i = 1'b0;
        adr_i = 4'h0;
        dat_i = 32'h0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check1(go, 1'b0);
        check1(bsel, 1'b0);
        check1(irq, 1'b0);
        wb(1'b0, vcb_pkg::CTRL_OFFS, 32'h0);
        check(q, vcb_pkg::CTRL_RST);
        wb(1'b0, vcb_pkg::MISC_OFFS, 32'h0);
        check(q, vcb_pkg::MISC_RST);
        wb(1'b1, 4'h2, 32'hffff_ffff);
        wb(1'b0, 4'h2, 32'h0);
        check(q, 32'h0);
        // Single continuous with both flags clear
        wb(1'b1, vcb_pkg::CTRL_OFFS, 32'h0000_0001);
        frame(1'b1, 1'b0, 1'b0);
        frame(1'b1, 1'b0, 1'b0);
        // Double continuous, overlay follows the idle buffer
        wb(1'b1, vcb_pkg::MISC_OFFS, 32'h0100_0000);
        check1(oauto, 1'b1);
        wb(1'b1, vcb_pkg::CTRL_OFFS, 32'h0000_0201);
        frame(1'b1, 1'b0, 1'b1);
        frame(1'b1, 1'b1, 1'b0);
        frame(1'b1, 1'b0, 1'b1);
        // Single conditional; pointer left at buffer two must not matter
        wb(1'b1, vcb_pkg::MISC_OFFS, 32'h0);
        check1(oauto, 1'b0);
        wb(1'b1, vcb_pkg::CTRL_OFFS, 32'h0000_0101);
        frame(1'b0, 1'b0, 1'b0);
        far.blit_set(2'b01);
        wb(1'b0, vcb_pkg::CTRL_OFFS, 32'h0);
        check(q & 32'h6, 32'h2);
        frame(1'b1, 1'b0, 1'b0);
        wb(1'b0, vcb_pkg::CTRL_OFFS, 32'h0);
        check(q & 32'h6, 32'h0);
        // Interrupt: frame done and buffer one cleared are pending
        wb(1'b0, 4'hc, 32'h0);
        check(q, 32'h3);
        check1(irq, 1'b0);
        wb(1'b1, 4'h8, 32'h2);
        check1(irq, 1'b1);
        wb(1'b1, 4'hc, 32'h2);
        wb(1'b0, 4'hc, 32'h0);
        check(q, 32'h1);
        check1(irq, 1'b0);
        wb(1'b1, 4'h8, 32'h0);
        // Double conditional from the preset 11b
        wb(1'b1, vcb_pkg::CTRL_OFFS, 32'h0000_0307);
        frame(1'b1, 1'b0, 1'b0);
        frame(1'b1, 1'b1, 1'b0);
        frame(1'b0, 1'b0, 1'b0);
        wb(1'b0, vcb_pkg::CTRL_OFFS, 32'h0);
        check(q & 32'h6, 32'h0);
        far.blit_set(2'b10);
        frame(1'b1, 1'b1, 1'b0);
        // Interlace needs double buffering as well
        wb(1'b1, vcb_pkg::CTRL_OFFS, 32'h0000_0601);
        check1(ilace, 1'b1);
        wb(1'b1, vcb_pkg::CTRL_OFFS, 32'h0000_0401);
        check1(ilace, 1'b0);
        // Reset mid-run with buffer two selected and capture enabled
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check1(go, 1'b0);
        check1(bsel, 1'b0);
        wb(1'b0, vcb_pkg::CTRL_OFFS, 32'h0);
        check(q, vcb_pkg::CTRL_RST);
        wb(1'b0, 4'hc, 32'h0);
        check(q, {29'h0, vcb_pkg::IRQ_RST});
        frame(1'b0, 1'b0, 1'b0);
        wb(1'b1, vcb_pkg::CTRL_OFFS, 32'h0);
        frame(1'b0, 1'b0, 1'b0);
        give_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge clk_i);
        failures++;
        $display("ERROR %0t run timeout", $time);
        give_verdict();
    end
endmodule
